// ===== rrsfe_pkg.sv
// Package with opcode patterns, field positions, address constants and phase encoding
package rrsfe_pkg;

	// ***********************************
	// Instruction word layout
	// ***********************************
	localparam int          RRSFE_INSTR_W     = 16;
	localparam int          RRSFE_DATA_W      = 8;
	localparam int          RRSFE_ADDR_W      = 12;
	localparam int          RRSFE_BANK_W      = 4;
	localparam int          RRSFE_POS_DEST    = 9;
	localparam int          RRSFE_POS_ACCESS  = 8;
	localparam logic [5:0]  RRSFE_RRNC_PREFIX = 6'h10;
	localparam logic [6:0]  RRSFE_SET_FILE_ALL_ONES_OP_PREFIX = 7'h34;

	// ***********************************
	// Addressing constants
	// ***********************************
	localparam logic [7:0]  RRSFE_OFFSET_LIMIT = 8'h5f;
	localparam logic [7:0]  RRSFE_ALL_ONES     = 8'hff;
	localparam logic [3:0]  RRSFE_ACCESS_HIGH  = 4'hf;
	localparam logic [RRSFE_ADDR_W-1:0] RRSFE_ADDR_RST = 12'h000;
	localparam logic [RRSFE_DATA_W-1:0] RRSFE_DATA_RST = 8'h00;

	// ***********************************
	// Phase sequence of one instruction cycle
	// ***********************************
	typedef enum logic [1:0] {
		RRSFE_PH_DECODE  = 2'b00,
		RRSFE_PH_READ    = 2'b01,
		RRSFE_PH_PROCESS = 2'b10,
		RRSFE_PH_WRITE   = 2'b11
	} rrsfe_phase_e;

endpackage : rrsfe_pkg

// ===== rrsfe_dec_if.sv
// Interface carrying decoded instruction fields between decoder and executor
interface rrsfe_dec_if;
	import rrsfe_pkg::*;
	logic                    is_rrnc;
	logic                    is_set_file_all_ones_op;
	logic                    dest_file;
	logic                    use_bank;
	logic [RRSFE_DATA_W-1:0] file_addr;

	modport drv (output is_rrnc, is_set_file_all_ones_op, dest_file, use_bank, file_addr);
	modport rcv (input is_rrnc, is_set_file_all_ones_op, dest_file, use_bank, file_addr);
endinterface : rrsfe_dec_if

// ===== rrsfe_decode.sv
// Opcode recognition and field extraction
module rrsfe_decode
	import rrsfe_pkg::*;
(
	input  wire logic [RRSFE_INSTR_W-1:0] instr_i,
	rrsfe_dec_if.drv                      dec
);

	// ***********************************
	// Opcode match
	// ***********************************
	assign dec.is_rrnc   = (instr_i[15:10] == RRSFE_RRNC_PREFIX);
	assign dec.is_set_file_all_ones_op   = (instr_i[15:9] == RRSFE_SET_FILE_ALL_ONES_OP_PREFIX);
	assign dec.dest_file = instr_i[RRSFE_POS_DEST];
	assign dec.use_bank  = instr_i[RRSFE_POS_ACCESS];
	assign dec.file_addr = instr_i[7:0];

endmodule : rrsfe_decode

// ===== rrsfe_exec.sv
// Execution of rotate-right-no-carry and set-file-all-ones instructions
// How it works
// - The rotate opcode is matched on its fixed upper six bits, with d, a and the address below.
// - Rotate moves every bit one place toward bit 0, bit 0 wraps to bit 7, only N and Z update.
// - For a rotate, d low sends the result to the working register, d high back to the file register; set-file always writes the file register.
// - With a low the access bank is used, with a high the bank select register forms the address.
// - With a low, extended set on and address at or below 5Fh, the address is an offset from the index base.
// - Each instruction is one word and takes four phases: decode, read, process, write.
// - An omitted bank-access operand is assembled as a high, so bank select addressing applies.
module rrsfe_exec
	import rrsfe_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    instr_valid_i,
	input  wire logic [RRSFE_INSTR_W-1:0] instr_i,
	input  wire logic [RRSFE_BANK_W-1:0] bank_select_register_i,
	input  wire logic                    ext_set_en_i,
	input  wire logic [RRSFE_ADDR_W-1:0] index_base_i,
	input  wire logic [RRSFE_DATA_W-1:0] file_rdata_i,
	input  wire logic [RRSFE_DATA_W-1:0] wreg_i,
	output logic      [RRSFE_ADDR_W-1:0] file_addr_o,
	output logic                         file_rd_o,
	output logic                         file_we_o,
	output logic      [RRSFE_DATA_W-1:0] file_wdata_o,
	output logic                         wreg_we_o,
	output logic      [RRSFE_DATA_W-1:0] wreg_wdata_o,
	output logic                         flag_we_o,
	output logic                         neg_flag_o,
	output logic                         zero_flag_o,
	output logic      [1:0]              phase_o,
	output logic                         busy_o
);

	// ***********************************
	// Decode
	// ***********************************
	rrsfe_dec_if dec_bus ();

	rrsfe_decode u_decode (
		.instr_i (instr_i),
		.dec     (dec_bus)
	);

	// ***********************************
	// Address formation
	// ***********************************
	logic [RRSFE_ADDR_W-1:0] bank_addr;
	logic [RRSFE_ADDR_W-1:0] access_addr;
	logic [RRSFE_ADDR_W-1:0] indexed_addr;
	logic                    use_indexed;
	logic [RRSFE_ADDR_W-1:0] eff_addr;
	logic                    known_op;

	assign known_op     = dec_bus.is_rrnc | dec_bus.is_set_file_all_ones_op;
	assign bank_addr    = {bank_select_register_i, dec_bus.file_addr};
	assign access_addr  = dec_bus.file_addr[7] ? {RRSFE_ACCESS_HIGH, dec_bus.file_addr}
	                                          : {4'h0, dec_bus.file_addr};
	assign indexed_addr = index_base_i + {4'h0, dec_bus.file_addr};
	assign use_indexed  = !dec_bus.use_bank && ext_set_en_i
	                      && (dec_bus.file_addr <= RRSFE_OFFSET_LIMIT);
	assign eff_addr     = dec_bus.use_bank ? bank_addr
	                    : (use_indexed ? indexed_addr : access_addr);

	// ***********************************
	// Phase sequencer
	// ***********************************
	rrsfe_phase_e ph_q, ph_d;
	logic         rrnc_q, set_file_all_ones_op_q, dest_q;
	logic [RRSFE_DATA_W-1:0] result_q;
	logic [RRSFE_DATA_W-1:0] rot_d;

	// ***********************************
	// Rotate one place toward bit 0
	// ***********************************
	for (genvar gi = 0; gi < RRSFE_DATA_W; gi++) begin : g_rot
		if (gi == RRSFE_DATA_W - 1) begin : g_wrap
			assign rot_d[gi] = file_rdata_i[0];
		end else begin : g_shift
			assign rot_d[gi] = file_rdata_i[gi+1];
		end
	end

	always_comb begin
		case (ph_q)
			RRSFE_PH_DECODE:  ph_d = (instr_valid_i && known_op) ? RRSFE_PH_READ : RRSFE_PH_DECODE;
			RRSFE_PH_READ:    ph_d = RRSFE_PH_PROCESS;
			RRSFE_PH_PROCESS: ph_d = RRSFE_PH_WRITE;
			RRSFE_PH_WRITE:   ph_d = RRSFE_PH_DECODE;
			default:          ph_d = RRSFE_PH_DECODE;
		endcase
	end

	logic go_dec, go_rd, go_proc;
	assign go_dec  = (ph_q == RRSFE_PH_DECODE) && instr_valid_i && known_op;
	assign go_rd   = (ph_q == RRSFE_PH_READ);
	assign go_proc = (ph_q == RRSFE_PH_PROCESS);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ph_q   <= RRSFE_PH_DECODE;
			rrnc_q <= 1'b0;
			set_file_all_ones_op_q <= 1'b0;
			dest_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			if (go_dec) begin
				rrnc_q <= dec_bus.is_rrnc;
				set_file_all_ones_op_q <= dec_bus.is_set_file_all_ones_op;
				dest_q <= dec_bus.dest_file | dec_bus.is_set_file_all_ones_op;
			end
		end
	end

	// ***********************************
	// File access request
	// ***********************************
	// Address held until the next instruction is taken
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			file_addr_o <= RRSFE_ADDR_RST;
		end else if (go_dec) begin
			file_addr_o <= eff_addr;
		end
	end

	// Read strobe marks the read phase
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			file_rd_o <= 1'b0;
		end else begin
			file_rd_o <= go_dec;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			result_q <= RRSFE_DATA_RST;
		end else if (go_rd) begin
			result_q <= set_file_all_ones_op_q ? RRSFE_ALL_ONES : rot_d;
		end
	end

	// ***********************************
	// Write-back
	// ***********************************
	logic file_we_d;
	logic wreg_we_d;
	logic flag_we_d;
	logic neg_d;
	logic zero_d;

	assign file_we_d = go_proc && dest_q;
	assign wreg_we_d = go_proc && !dest_q;
	assign flag_we_d = go_proc && rrnc_q;
	assign neg_d     = result_q[RRSFE_DATA_W-1];
	assign zero_d    = (result_q == RRSFE_DATA_RST);

	// Strobes, one phase wide
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			file_we_o <= 1'b0;
			wreg_we_o <= 1'b0;
			flag_we_o <= 1'b0;
		end else begin
			file_we_o <= file_we_d;
			wreg_we_o <= wreg_we_d;
			flag_we_o <= flag_we_d;
		end
	end

	// File data, held until the next write
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			file_wdata_o <= RRSFE_DATA_RST;
		end else if (go_proc) begin
			file_wdata_o <= result_q;
		end
	end

	// Working register data, held until the next write
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wreg_wdata_o <= RRSFE_DATA_RST;
		end else if (go_proc) begin
			wreg_wdata_o <= result_q;
		end
	end

	// ***********************************
	// Status flags
	// ***********************************
	// Only a rotate touches the flags
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			neg_flag_o  <= 1'b0;
			zero_flag_o <= 1'b0;
		end else if (flag_we_d) begin
			neg_flag_o  <= neg_d;
			zero_flag_o <= zero_d;
		end
	end

	// ***********************************
	// Phase outputs
	// ***********************************
	logic busy_d;

	assign busy_d = (ph_d != RRSFE_PH_DECODE);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_o <= 2'b00;
		end else begin
			phase_o <= ph_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= busy_d;
		end
	end

	logic unused_w;
	assign unused_w = ^wreg_i;

endmodule : rrsfe_exec

// ===== rrsfe_checker.sv
// Checker of the rotate and set-file executor
module rrsfe_checker
	import rrsfe_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [3:0]  bank_select_register_i,
	input wire logic        ext_set_en_i,
	input wire logic [11:0] index_base_i,
	input wire logic [7:0]  file_rdata_i,
	input wire logic [11:0] file_addr_o,
	input wire logic        file_rd_o,
	input wire logic        file_we_o,
	input wire logic [7:0]  file_wdata_o,
	input wire logic        wreg_we_o,
	input wire logic [7:0]  wreg_wdata_o,
	input wire logic        flag_we_o,
	input wire logic        neg_flag_o,
	input wire logic        zero_flag_o,
	input wire logic [1:0]  phase_o,
	input wire logic        busy_o
);
	logic [7:0]  rd_q;
	wire  [7:0]  f   = instr_i[7:0];
	wire  [7:0]  rot = {rd_q[0], rd_q[7:1]};
	wire         tk  = phase_o == 2'h0 && instr_valid_i &&
		(instr_i[15:10] == RRSFE_RRNC_PREFIX || instr_i[15:9] == RRSFE_SET_FILE_ALL_ONES_OP_PREFIX);
	wire  [11:0] ea  = instr_i[8] ? {bank_select_register_i, f} :
		(ext_set_en_i && f <= 8'h5f) ? index_base_i + 12'(f) : {f[7] ? 4'hf : 4'h0, f};
	always_ff @(posedge clk_i) if (phase_o == 2'h1) rd_q <= file_rdata_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_TAKE: assert property (tk |=> file_rd_o && file_addr_o == $past(ea))
		else $error("bad take");
	AST_IDLE: assert property (phase_o == 2'h0 && !tk |=> !file_rd_o)
		else $error("bad idle");
	AST_PHASE: assert property (file_rd_o |-> phase_o == 2'h1 ##1 phase_o == 2'h2
		##1 phase_o == 2'h3 && (file_we_o || wreg_we_o) ##1 phase_o == 2'h0) else $error("phase");
	AST_BUSY: assert property (busy_o == (phase_o != 2'h0))
		else $error("busy");
	AST_WREG: assert property (wreg_we_o |-> wreg_wdata_o == rot && !file_we_o)
		else $error("wreg");
	AST_FLAGS: assert property (flag_we_o |-> neg_flag_o == rot[7] && zero_flag_o == !rot)
		else $error("flags");
	AST_FROT: assert property (file_we_o && flag_we_o |-> file_wdata_o == rot)
		else $error("file rot");
	AST_SET_FILE_ALL_ONES_OP: assert property (file_we_o && !flag_we_o |-> file_wdata_o == 8'hff)
		else $error("set");
	AST_HOLD: assert property (!flag_we_o |-> $stable(neg_flag_o) && $stable(zero_flag_o))
		else $error("hold");
endmodule : rrsfe_checker

bind rrsfe_exec rrsfe_checker chk_u (.*);

// ===== rrsfe_exec_tb_top.sv
// Testbench of the rotate and set-file executor
module rrsfe_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_n_i = 0, instr_valid_i = 0, ext_set_en_i = 0;
	logic [15:0] instr_i = '0;
	logic [3:0]  bank_select_register_i = '0;
	logic [11:0] index_base_i = 12'hfc0, file_addr_o;
	logic [7:0]  file_rdata_i = '0, wreg_i = '0, file_wdata_o, wreg_wdata_o;
	logic        file_rd_o, file_we_o, wreg_we_o, flag_we_o, neg_flag_o, zero_flag_o, busy_o;
	logic [1:0]  phase_o;
	int          err_total = 0, checks_done = 0, cyc = 0;
	rrsfe_exec dut_u (.*);
	always #2.5 clk_i = ~clk_i;
	task automatic chk(logic [11:0] got, logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("Mismatches %0d of %0d checks", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			err_total++;
			final_report();
		end
	end
	task automatic step;
		@(posedge clk_i);
		#1;
	endtask : step
	// One instruction, back to back with the next
	task automatic run_op(logic [15:0] op, logic [3:0] bank, logic ext, logic [7:0] rd,
		logic [11:0] ea, logic fwe, logic [7:0] res, logic n, logic z);
		instr_i = op;
		instr_valid_i = 1'b1;
		bank_select_register_i = bank;
		ext_set_en_i = ext;
		step();
		instr_valid_i = 1'b0;
		file_rdata_i = rd;
		chk(file_addr_o, ea);
		chk(file_rd_o, 1);
		step();
		file_rdata_i = ~rd;
		step();
		chk(file_we_o, fwe);
		chk(wreg_we_o, !fwe);
		chk(flag_we_o, !op[13]);
		chk(fwe ? file_wdata_o : wreg_wdata_o, res);
		step();
		chk({neg_flag_o, zero_flag_o, busy_o}, {n, z, 1'b0});
	endtask : run_op
	task automatic t_ignore;
		instr_valid_i = 1'b1;
		instr_i = 16'h4433;
		step();
		chk(file_rd_o, 0);
		instr_i = 16'h6b00;
		step();
		chk(busy_o, 0);
		instr_valid_i = 1'b0;
		instr_i = 16'h4133;
		step();
		chk(phase_o, 0);
	endtask : t_ignore
	task automatic t_rotate;
		run_op(16'h4133, 4'h5, 0, 8'hd7, 12'h533, 0, 8'heb, 1, 0);
		run_op(16'h4290, 4'h5, 1, 8'h01, 12'hf90, 1, 8'h80, 1, 0);
		run_op(16'h425f, 4'h5, 1, 8'h02, 12'h01f, 1, 8'h01, 0, 0);
		run_op(16'h4060, 4'h5, 1, 8'h00, 12'h060, 0, 8'h00, 0, 1);
	endtask : t_rotate
	task automatic t_set_file_all_ones_op;
		run_op(16'h69a5, 4'hc, 0, 8'h5a, 12'hca5, 1, 8'hff, 0, 1);
		run_op(16'h6845, 4'hc, 1, 8'h33, 12'h005, 1, 8'hff, 0, 1);
	endtask : t_set_file_all_ones_op
	initial begin
		repeat (10) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		step();
		t_ignore();
		t_rotate();
		t_set_file_all_ones_op();
		final_report();
	end
endmodule : rrsfe_exec_tb_top
